// ==== hdl/hcm_host_cmd_mailbox.sv ====
// host command mailbox: buffer window, command queue and reply blocks
`timescale 1ns/1ps
`default_nettype none
module hcm_host_cmd_mailbox #(
  parameter longint unsigned TIMEOUT_CYCLES = hcm_pkg::TIMEOUT_CYCLES
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_map_we,
  input wire hcm_pkg::hcm_map_t i_map,
  input wire logic i_req_valid,
  input wire hcm_pkg::hcm_req_t i_req,
  output logic o_req_ready,
  output logic o_req_reject,
  input wire logic i_wr_valid,
  input wire logic [7:0] i_wr_byte,
  output logic o_wr_ready,
  output logic o_ack_valid,
  output logic [7:0] o_ack_code,
  output logic o_rd_valid,
  output logic [7:0] o_rd_byte,
  output logic o_rd_last,
  input wire logic i_rd_ready,
  output logic o_cmd_valid,
  output logic [7:0] o_cmd_char,
  input wire logic i_cmd_ready,
  input wire logic i_cmd_pending,
  input wire logic i_rep_valid,
  input wire logic [7:0] i_rep_char,
  output logic o_rep_ready,
  output logic o_abort,
  output logic o_cmd_full
);
  typedef enum logic [1:0] {S_IDLE, S_WRITE, S_ACK, S_READ} hcm_state_t;
  localparam int BLK = hcm_pkg::BLK_BYTES;

  hcm_state_t st_q, st_d;
  hcm_pkg::hcm_map_t map_q, map_d;
  logic [7:0] echo_q [BLK];
  logic [7:0] echo_d [BLK];
  logic [7:0] blk_q [BLK];
  logic [7:0] blk_d [BLK];
  logic [6:0] blk_cnt_q, blk_cnt_d;
  logic [7:0] src_q, src_d, ack_q, ack_d, rdb_q, rdb_d, first_q, first_d;
  logic [9:0] off_q, off_d, end_q, end_d, wcnt_q, wcnt_d, size_q, size_d;
  logic is_rd_q, is_rd_d, in_cmd_q, in_cmd_d, cons_q, cons_d, inj_q, inj_d, rej_q, rej_d;
  logic [8:0] len_q, len_d;
  logic [15:0] cdiff, rdiff;
  logic [9:0] start_off, cap;
  logic hit_cmd, hit_rep, wr_fire, rd_fire, clr, expire, fill;
  logic cq_full, cq_empty, rq_full, rq_empty, rq_push, inj_ok;
  logic [7:0] rq_data, rq_in;

  // byte view of the window: command echo, source number, reply block, nulls
  function automatic logic [7:0] get_byte(input logic [9:0] ofs);
    logic [9:0] t;
    t = 10'(ofs - hcm_pkg::TXT_OFS);
    if (ofs < hcm_pkg::CMD_AREA_BYTES) begin
      get_byte = echo_q[ofs[6:0]];
    end else if (ofs == hcm_pkg::SRC_OFS) begin
      get_byte = src_q;
    end else if (ofs <= hcm_pkg::TXT_LAST) begin
      get_byte = blk_q[t[6:0]];
    end else begin
      get_byte = hcm_pkg::CHR_NUL;
    end
  endfunction

  // request decode against the relocatable bases
  assign cdiff = 16'(i_req.addr - map_q.buf_base);
  assign rdiff = 16'(i_req.addr - map_q.rep_base);
  assign hit_cmd = cdiff < hcm_pkg::CMD_AREA_WORDS;
  assign hit_rep = rdiff < hcm_pkg::REP_AREA_WORDS;
  assign start_off = hit_cmd ? {cdiff[8:0], 1'b0} : 10'(hcm_pkg::SRC_OFS + {rdiff[8:0], 1'b0});
  assign cap = hit_cmd ? hcm_pkg::START_READ_MAX : hcm_pkg::AREA_BYTES;

  assign o_req_ready = (st_q == S_IDLE);
  assign o_wr_ready = (st_q == S_WRITE) && (!in_cmd_q || !cq_full);
  assign wr_fire = o_wr_ready && i_wr_valid;
  assign o_ack_valid = (st_q == S_ACK);
  assign o_ack_code = ack_q;
  assign o_rd_valid = (st_q == S_READ);
  assign o_rd_byte = rdb_q;
  assign o_rd_last = o_rd_valid && (10'(off_q + 1'b1) == end_q);
  assign rd_fire = o_rd_valid && i_rd_ready;
  assign o_req_reject = rej_q;
  assign o_cmd_full = cq_full;
  assign o_cmd_valid = !cq_empty;
  assign o_abort = expire;

  // a lone hash line empties all reply storage
  assign clr = wr_fire && in_cmd_q && (i_wr_byte == hcm_pkg::CHR_CR)
               && (len_q == 9'h001) && (first_q == hcm_pkg::CHR_HASH);
  // the abort prompt goes in ahead of interpreter text
  assign inj_ok = inj_q && !rq_full && !clr;
  assign o_rep_ready = !rq_full && !inj_q;
  assign rq_push = inj_ok || (i_rep_valid && o_rep_ready);
  assign rq_in = inj_q ? hcm_pkg::CHR_DASH : i_rep_char;
  // the block is frozen from a read's acknowledge on, so the first byte matches the rest
  assign fill = (st_q != S_READ) && !(st_q == S_ACK && is_rd_q)
                && (32'(blk_cnt_q) < BLK) && !rq_empty && !clr;

  hcm_fifo #(.W(8), .DEPTH(hcm_pkg::CMDQ_DEPTH)) u_cmdq (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_flush(1'b0),
    .i_push(wr_fire && in_cmd_q),
    .i_data(i_wr_byte),
    .i_pop(o_cmd_valid && i_cmd_ready),
    .o_data(o_cmd_char),
    .o_full(cq_full),
    .o_empty(cq_empty)
  );

  hcm_fifo #(.W(8), .DEPTH(hcm_pkg::REPQ_DEPTH)) u_repq (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_flush(clr),
    .i_push(rq_push),
    .i_data(rq_in),
    .i_pop(fill),
    .o_data(rq_data),
    .o_full(rq_full),
    .o_empty(rq_empty)
  );

  // a line still open, or a command still waiting for parameter lines, runs the timer
  hcm_timer #(.CYCLES(TIMEOUT_CYCLES)) u_timer (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_run((len_q != '0) || i_cmd_pending),
    .i_restart(wr_fire),
    .o_expire(expire)
  );

  always_comb begin
    st_d = st_q;
    map_d = map_q;
    echo_d = echo_q;
    blk_d = blk_q;
    blk_cnt_d = blk_cnt_q;
    src_d = src_q;
    ack_d = ack_q;
    rdb_d = rdb_q;
    first_d = first_q;
    off_d = off_q;
    end_d = end_q;
    wcnt_d = wcnt_q;
    size_d = size_q;
    is_rd_d = is_rd_q;
    in_cmd_d = in_cmd_q;
    cons_d = cons_q;
    len_d = len_q;
    rej_d = 1'b0;
    inj_d = expire || (inj_q && !inj_ok);
    if (i_map_we) begin
      map_d = i_map;
    end
    case (st_q)
      S_IDLE: begin
        if (i_req_valid) begin
          if ((i_req.cmd == hcm_pkg::CMD_WR_UNPROT || i_req.cmd == hcm_pkg::CMD_WR_PROT)
              && (hit_cmd || hit_rep)) begin
            ack_d = i_req.cmd | hcm_pkg::ACK_BIT;
            src_d = hit_cmd ? i_req.src : src_q;
            in_cmd_d = hit_cmd;
            is_rd_d = 1'b0;
            off_d = start_off;
            wcnt_d = '0;
            size_d = i_req.size;
            st_d = (i_req.size == '0) ? S_ACK : S_WRITE;
          end else if (i_req.cmd == hcm_pkg::CMD_RD && (hit_cmd || hit_rep)) begin
            ack_d = hcm_pkg::CMD_RD | hcm_pkg::ACK_BIT;
            is_rd_d = 1'b1;
            off_d = start_off;
            end_d = (10'(start_off + i_req.size) > cap) ? cap : 10'(start_off + i_req.size);
            rdb_d = get_byte(start_off);
            cons_d = 1'b0;
            st_d = S_ACK;
          end else begin
            rej_d = 1'b1;
          end
        end
      end
      S_WRITE: begin
        if (wr_fire) begin
          if (in_cmd_q && off_q < hcm_pkg::CMD_AREA_BYTES) begin
            echo_d[off_q[6:0]] = i_wr_byte;
          end
          off_d = 10'(off_q + 1'b1);
          wcnt_d = 10'(wcnt_q + 1'b1);
          if (10'(wcnt_q + 1'b1) == size_q) begin
            st_d = S_ACK;
          end
        end
      end
      S_ACK: begin
        // size 0 or a start at or past the cap answers with the code alone
        st_d = (is_rd_q && off_q < end_q) ? S_READ : S_IDLE;
        if (is_rd_q) begin
          rdb_d = get_byte(off_q);
        end
      end
      S_READ: begin
        if (rd_fire) begin
          if (off_q == hcm_pkg::TXT_LAST) begin
            cons_d = 1'b1;
          end
          off_d = 10'(off_q + 1'b1);
          rdb_d = get_byte(10'(off_q + 1'b1));
          if (o_rd_last) begin
            st_d = S_IDLE;
            // once the block's last byte went out the next one may load
            if (cons_q || off_q == hcm_pkg::TXT_LAST) begin
              blk_d = '{default: hcm_pkg::CHR_NUL};
              blk_cnt_d = '0;
            end
          end
        end
      end
      default: st_d = S_IDLE;
    endcase
    // line tracking sees only command-area bytes
    if (wr_fire && in_cmd_q) begin
      if (i_wr_byte == hcm_pkg::CHR_CR) begin
        len_d = '0;
      end else begin
        if (len_q == '0) begin
          first_d = i_wr_byte;
        end
        len_d = (len_q == '1) ? len_q : 9'(len_q + 1'b1);
      end
    end
    if (expire) begin
      len_d = '0;
    end
    if (fill) begin
      blk_d[blk_cnt_q] = rq_data;
      blk_cnt_d = 7'(blk_cnt_q + 1'b1);
    end
    if (clr) begin
      blk_d = '{default: hcm_pkg::CHR_NUL};
      blk_cnt_d = '0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    echo_q <= echo_d;
    if (i_rst) begin
      st_q <= S_IDLE;
      map_q <= '{buf_base: hcm_pkg::BUF_BASE_RST, rep_base: hcm_pkg::REP_BASE_RST};
      blk_q <= '{default: hcm_pkg::CHR_NUL};
      blk_cnt_q <= '0;
      src_q <= '0;
      ack_q <= '0;
      rdb_q <= '0;
      first_q <= '0;
      off_q <= '0;
      end_q <= '0;
      wcnt_q <= '0;
      size_q <= '0;
      is_rd_q <= 1'b0;
      in_cmd_q <= 1'b0;
      cons_q <= 1'b0;
      inj_q <= 1'b0;
      rej_q <= 1'b0;
      len_q <= '0;
    end else begin
      st_q <= st_d;
      map_q <= map_d;
      blk_q <= blk_d;
      blk_cnt_q <= blk_cnt_d;
      src_q <= src_d;
      ack_q <= ack_d;
      rdb_q <= rdb_d;
      first_q <= first_d;
      off_q <= off_d;
      end_q <= end_d;
      wcnt_q <= wcnt_d;
      size_q <= size_d;
      is_rd_q <= is_rd_d;
      in_cmd_q <= in_cmd_d;
      cons_q <= cons_d;
      inj_q <= inj_d;
      rej_q <= rej_d;
      len_q <= len_d;
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  sequence s_read_start;
    (st_q == S_ACK) && is_rd_q ##1 (st_q == S_READ);
  endsequence

  map_reset_a: assert property ($fell(i_rst) |-> map_q.buf_base == 16'h07d0 && map_q.rep_base == 16'h07f8)
    else $error("buffer bases not at reset values");
  write_ack_a: assert property (o_ack_valid && !is_rd_q |-> o_ack_code == 8'h48 || o_ack_code == 8'h40)
    else $error("bad write acknowledge code");
  read_ack_a: assert property (s_read_start |-> $past(o_ack_code) == 8'h41 && o_rd_valid)
    else $error("read not answered with 41H then data");
  src_byte_a: assert property (o_rd_valid && off_q == 10'h050 |-> o_rd_byte == src_q)
    else $error("source number missing from reply area");
  start_cap_a: assert property (o_rd_valid |-> end_q <= 10'h150 && off_q < end_q)
    else $error("read ran past its end");
  null_pad_a: assert property (o_rd_valid && off_q > 10'h050 + 10'(blk_cnt_q) |-> o_rd_byte == 8'h00)
    else $error("unused reply byte not null");
  clear_empty_a: assert property (clr |=> blk_cnt_q == 7'h00 && rq_empty ##1 o_rep_ready || rq_empty)
    else $error("clear left reply text behind");
  abort_dash_a: assert property (expire |=> inj_q && (rq_full || clr || (rq_push && rq_in == 8'h2d)))
    else $error("abort prompt not queued");
  cmd_full_a: assert property (cq_full && in_cmd_q |-> !o_wr_ready)
    else $error("command queue overrun");
  rep_full_a: assert property (rq_full && !fill && !clr |=> rq_full && !o_rep_ready)
    else $error("reply queue accepted past its size");
  block_next_a: assert property (rd_fire && o_rd_last && off_q == 10'h0a0 |=> blk_cnt_q == 7'h00)
    else $error("read block not released");
endmodule
`default_nettype wire

// ==== hdl/hcm_pkg.sv ====
// constants and carrier types of the host command mailbox
package hcm_pkg;
  localparam longint unsigned CLK_HZ = 64'd50_000_000;
  localparam longint unsigned TIMEOUT_S = 64'd120;
  localparam longint unsigned TIMEOUT_CYCLES = TIMEOUT_S * CLK_HZ;
  // decimal 2000 and 2040
  localparam logic [15:0] BUF_BASE_RST = 16'h07d0;
  localparam logic [15:0] REP_BASE_RST = 16'h07f8;
  localparam logic [15:0] CMD_AREA_WORDS = 16'h0028;
  localparam logic [15:0] REP_AREA_WORDS = 16'h0080;
  localparam logic [9:0] CMD_AREA_BYTES = 10'h050;
  localparam logic [9:0] SRC_OFS = 10'h050;
  localparam logic [9:0] TXT_OFS = 10'h051;
  localparam logic [9:0] TXT_LAST = 10'h0a0;
  localparam logic [9:0] START_READ_MAX = 10'h0f4;
  localparam logic [9:0] AREA_BYTES = 10'h150;
  localparam int BLK_BYTES = 80;
  localparam int CMDQ_DEPTH = 300;
  localparam int REPQ_DEPTH = 1300;
  localparam logic [7:0] CMD_WR_UNPROT = 8'h08;
  localparam logic [7:0] CMD_WR_PROT = 8'h00;
  localparam logic [7:0] CMD_RD = 8'h01;
  localparam logic [7:0] ACK_BIT = 8'h40;
  localparam logic [7:0] CHR_CR = 8'h0d;
  localparam logic [7:0] CHR_HASH = 8'h23;
  localparam logic [7:0] CHR_DASH = 8'h2d;
  localparam logic [7:0] CHR_NUL = 8'h00;

  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] src;
    logic [15:0] addr;
    logic [9:0] size;
  } hcm_req_t;

  typedef struct packed {
    logic [15:0] buf_base;
    logic [15:0] rep_base;
  } hcm_map_t;
endpackage

// ==== hdl/hcm_fifo.sv ====
// flip-flop character queue with flush
`timescale 1ns/1ps
`default_nettype none
module hcm_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 300
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_flush,
  input wire logic i_push,
  input wire logic [W-1:0] i_data,
  input wire logic i_pop,
  output logic [W-1:0] o_data,
  output logic o_full,
  output logic o_empty
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  if (DEPTH < 2 || W < 1) begin : g_chk
    $error("hcm_fifo: DEPTH must be at least 2");
  end
  logic [W-1:0] mem_q [DEPTH];
  logic [W-1:0] mem_d [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic do_push, do_pop;

  function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
    inc = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  assign o_full = (cnt_q == CW'(DEPTH));
  assign o_empty = (cnt_q == '0);
  assign o_data = mem_q[rp_q];
  assign do_push = i_push && !o_full && !i_flush;
  assign do_pop = i_pop && !o_empty && !i_flush;

  always_comb begin
    mem_d = mem_q;
    wp_d = do_push ? inc(wp_q) : wp_q;
    rp_d = do_pop ? inc(rp_q) : rp_q;
    cnt_d = CW'(cnt_q + CW'(do_push) - CW'(do_pop));
    if (do_push) begin
      mem_d[wp_q] = i_data;
    end
    if (i_flush) begin
      wp_d = '0;
      rp_d = '0;
      cnt_d = '0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    mem_q <= mem_d;
    if (i_rst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end
endmodule
`default_nettype wire

// ==== hdl/hcm_timer.sv ====
// idle timer that pulses each time a run lasts the full count, then counts again from zero
`timescale 1ns/1ps
`default_nettype none
module hcm_timer #(
  parameter longint unsigned CYCLES = hcm_pkg::TIMEOUT_CYCLES
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_run,
  input wire logic i_restart,
  output logic o_expire
);
  if (CYCLES < 1 || CYCLES >= 64'h0000_0002_0000_0000) begin : g_chk
    $error("hcm_timer: CYCLES out of range");
  end
  logic [32:0] cnt_q, cnt_d;
  logic exp_q, exp_d;

  always_comb begin
    cnt_d = 33'(cnt_q + 1'b1);
    exp_d = 1'b0;
    if (!i_run || i_restart) begin
      cnt_d = '0;
    end else if (cnt_q == 33'(CYCLES - 1)) begin
      cnt_d = '0;
      exp_d = 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      cnt_q <= '0;
      exp_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      exp_q <= exp_d;
    end
  end
  assign o_expire = exp_q;
endmodule
`default_nettype wire

// ==== verification/hcm_host_model.sv ====
// host computer model: block writes and block reads towards the mailbox
`timescale 1ns/1ps
`default_nettype none
module hcm_host_model (
  input wire logic i_core_clk,
  input wire logic i_req_ready,
  input wire logic i_req_reject,
  input wire logic i_wr_ready,
  input wire logic i_ack_valid,
  input wire logic [7:0] i_ack_code,
  input wire logic i_rd_valid,
  input wire logic [7:0] i_rd_byte,
  input wire logic i_rd_last,
  output logic o_req_valid,
  output var hcm_pkg::hcm_req_t o_req,
  output logic o_wr_valid,
  output logic [7:0] o_wr_byte,
  output logic o_rd_ready
);
  logic [7:0] code;
  logic [7:0] rx[$];
  bit rej;
  bit tmo;
  int last_n;
  string txt;

  initial begin
    o_req_valid = 1'b0;
    o_req = '0;
    o_wr_valid = 1'b0;
    o_wr_byte = 8'h00;
    o_rd_ready = 1'b0;
    tmo = 1'b0;
  end

  // one message; every wait is bounded and sets tmo when it runs out
  task automatic blk(input logic [7:0] cmd, input logic [7:0] src, input logic [15:0] addr,
                     input string d, input int rsz, input bit slow);
    int n;
    int k;
    bit r;
    bit done;
    bit rd;
    rd = (cmd == hcm_pkg::CMD_RD);
    n = rd ? rsz : d.len();
    rx.delete();
    txt = "";
    code = 8'h00;
    rej = 1'b0;
    done = 1'b0;
    last_n = 0;
    k = 0;
    @(posedge i_core_clk);
    o_req_valid <= 1'b1;
    o_req <= '{cmd, src, addr, n[9:0]};
    do begin
      @(negedge i_core_clk);
      r = i_req_ready;
      @(posedge i_core_clk);
      k++;
    end while (!r && k < 100);
    o_req_valid <= 1'b0;
    o_req <= ~o_req;
    for (int i = 0; i < n && !rd; i++) begin
      o_wr_valid <= 1'b1;
      o_wr_byte <= d[i];
      do begin
        @(negedge i_core_clk);
        r = i_wr_ready;
        @(posedge i_core_clk);
        k++;
      end while (!r && k < 2000);
    end
    // a released data line shows the inverse, never the last byte
    o_wr_valid <= 1'b0;
    o_wr_byte <= ~o_wr_byte;
    o_rd_ready <= rd;
    while (!done && k < 2000) begin
      @(negedge i_core_clk);
      if (i_ack_valid) code = i_ack_code;
      if (i_req_reject) rej = 1'b1;
      if (i_rd_valid && o_rd_ready) begin
        rx.push_back(i_rd_byte);
        if (i_rd_last) last_n = rx.size();
      end
      done = rej || last_n > 0 || (code != 8'h00 && !rd);
      @(posedge i_core_clk);
      k++;
      o_rd_ready <= !done && rd && (!slow || !o_rd_ready);
    end
    tmo = tmo || !done;
    for (int i = 1; i < rx.size(); i++) begin
      if (rx[i] != 8'h00) begin
        txt = {txt, " "};
        txt.putc(txt.len() - 1, rx[i]);
      end
    end
  endtask
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
// self-checking bench of the host command mailbox
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam longint unsigned TMO = 64'd50;
  logic clk, rst, map_we, req_valid, req_ready, req_reject, wr_valid, wr_ready, ack_valid;
  logic rd_valid, rd_last, rd_ready, cmd_valid, cmd_ready, cmd_pending, rep_valid, rep_ready;
  logic abort, cmd_full;
  logic [7:0] wr_byte, ack_code, rd_byte, cmd_char, rep_char;
  hcm_pkg::hcm_map_t map;
  hcm_pkg::hcm_req_t req;
  int n_fail = 0;
  int check_count = 0;
  string cmds;

  hcm_host_cmd_mailbox #(.TIMEOUT_CYCLES(TMO)) u_hcm_host_cmd_mailbox (.i_core_clk(clk), .i_rst(rst),
    .i_map_we(map_we), .i_map(map), .i_req_valid(req_valid), .i_req(req), .o_req_ready(req_ready),
    .o_req_reject(req_reject), .i_wr_valid(wr_valid), .i_wr_byte(wr_byte), .o_wr_ready(wr_ready),
    .o_ack_valid(ack_valid), .o_ack_code(ack_code), .o_rd_valid(rd_valid), .o_rd_byte(rd_byte),
    .o_rd_last(rd_last), .i_rd_ready(rd_ready), .o_cmd_valid(cmd_valid), .o_cmd_char(cmd_char),
    .i_cmd_ready(cmd_ready), .i_cmd_pending(cmd_pending), .i_rep_valid(rep_valid),
    .i_rep_char(rep_char), .o_rep_ready(rep_ready), .o_abort(abort), .o_cmd_full(cmd_full));

  hcm_host_model u_hcm_host_model (.i_core_clk(clk), .i_req_ready(req_ready),
    .i_req_reject(req_reject), .i_wr_ready(wr_ready), .i_ack_valid(ack_valid),
    .i_ack_code(ack_code), .i_rd_valid(rd_valid), .i_rd_byte(rd_byte), .i_rd_last(rd_last),
    .o_req_valid(req_valid), .o_req(req), .o_wr_valid(wr_valid), .o_wr_byte(wr_byte),
    .o_rd_ready(rd_ready));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // interpreter side: collect every queued command character
  always @(negedge clk) begin
    if (cmd_valid && cmd_ready) begin
      cmds = {cmds, " "};
      cmds.putc(cmds.len() - 1, cmd_char);
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic chks(input string nm, input string e, input string g);
    check_count++;
    if (g != e) begin
      n_fail++;
      $display("CHECK FAILED %s expected '%s' seen '%s'", nm, e, g);
    end
  endtask

  task automatic h(input logic [7:0] cmd, input logic [7:0] src, input logic [15:0] addr,
                   input string d, input int rsz, input bit slow);
    u_hcm_host_model.blk(cmd, src, addr, d, rsz, slow);
    if (u_hcm_host_model.tmo) begin
      n_fail++;
      $display("CHECK FAILED host handshake expected done seen stuck");
      give_verdict();
    end
  endtask

  // interpreter reply characters, held until the mailbox takes them
  task automatic feed(input string s);
    int k;
    bit r;
    k = 0;
    @(posedge clk);
    for (int i = 0; i < s.len(); i++) begin
      rep_valid <= 1'b1;
      rep_char <= s[i];
      do begin
        @(negedge clk);
        r = rep_ready;
        @(posedge clk);
        k++;
      end while (!r && k < 500);
    end
    rep_valid <= 1'b0;
    rep_char <= ~rep_char;
    if (k >= 500) begin
      n_fail++;
      $display("CHECK FAILED reply feed expected taken seen stuck");
      give_verdict();
    end
  endtask

  task automatic t_reset();
    h(8'h01, 8'h00, 16'h07f8, "", 81, 0);
    chk("reply area taken", 8'h00, {7'h00, u_hcm_host_model.rej});
    chk("read ack", 8'h41, u_hcm_host_model.code);
    chk("read count", 8'd81, 8'(u_hcm_host_model.rx.size()));
    chk("src after reset", 8'h00, u_hcm_host_model.rx[0]);
    chks("text after reset", "", u_hcm_host_model.txt);
    $display("test reset done");
  endtask

  task automatic t_write();
    int k;
    cmds = "";
    h(8'h08, 8'h05, 16'h07d0, "AB\015", 0, 0);
    chk("unprotected ack", 8'h48, u_hcm_host_model.code);
    h(8'h00, 8'h06, 16'h07d0, "C\015", 0, 0);
    chk("protected ack", 8'h40, u_hcm_host_model.code);
    for (k = 0; k < 50 && cmds.len() < 5; k++) @(posedge clk);
    chks("queued lines", "AB\015C\015", cmds);
    h(8'h01, 8'h00, 16'h07d0, "", 300, 0);
    chk("start read count", 8'd244, 8'(u_hcm_host_model.rx.size()));
    chk("start read last", 8'd244, 8'(u_hcm_host_model.last_n));
    chk("echo first byte", "C", u_hcm_host_model.rx[0]);
    chk("echoed src", 8'h06, u_hcm_host_model.rx[80]);
    $display("test write done");
  endtask

  task automatic t_blocks();
    string s;
    s = "";
    repeat (80) s = {s, "r"};
    feed({s, "OK\015"});
    repeat (10) @(posedge clk);
    h(8'h01, 8'h00, 16'h07f8, "", 81, 1);
    chk("first block src", 8'h06, u_hcm_host_model.rx[0]);
    chks("first block", s, u_hcm_host_model.txt);
    repeat (10) @(posedge clk);
    h(8'h01, 8'h00, 16'h07f8, "", 81, 0);
    chks("second block", "OK\015", u_hcm_host_model.txt);
    chk("padding", 8'h00, u_hcm_host_model.rx[4]);
    $display("test blocks done");
  endtask

  task automatic t_clear();
    feed("ZZ\015");
    repeat (10) @(posedge clk);
    h(8'h08, 8'h07, 16'h07d0, "#\015", 0, 0);
    h(8'h01, 8'h00, 16'h07f8, "", 81, 0);
    chks("cleared reply", "", u_hcm_host_model.txt);
    chk("src after clear", 8'h07, u_hcm_host_model.rx[0]);
    $display("test clear done");
  endtask

  task automatic t_abort();
    int k;
    h(8'h08, 8'h08, 16'h07d0, "X", 0, 0);
    k = 0;
    while (!abort && k < 300) begin
      @(negedge clk);
      k++;
    end
    chk("abort delay", 8'h01, {7'h00, k > 40 && k < 60});
    repeat (10) @(posedge clk);
    h(8'h01, 8'h00, 16'h07f8, "", 81, 0);
    chks("abort prompt", "-", u_hcm_host_model.txt);
    // an interpreter waiting for parameter lines keeps the timer running as well
    @(posedge clk);
    cmd_pending <= 1'b1;
    k = 0;
    while (!abort && k < 300) begin
      @(negedge clk);
      k++;
    end
    chk("pending abort delay", 8'h01, {7'h00, k > 40 && k < 60});
    @(posedge clk);
    cmd_pending <= 1'b0;
    h(8'h01, 8'h00, 16'h07f8, "", 81, 0);
    chks("pending prompt", "-", u_hcm_host_model.txt);
    $display("test abort done");
  endtask

  task automatic t_map();
    h(8'h02, 8'h01, 16'h07d0, "", 0, 0);
    chk("bad command", 8'h01, {7'h00, u_hcm_host_model.rej});
    @(posedge clk);
    map_we <= 1'b1;
    map <= '{16'h0bb8, 16'h0be0};
    @(posedge clk);
    map_we <= 1'b0;
    h(8'h08, 8'h09, 16'h0bb8, "\015", 0, 0);
    chk("moved buffer", 8'h48, u_hcm_host_model.code);
    h(8'h01, 8'h00, 16'h07f8, "", 81, 0);
    chk("old reply area", 8'h01, {7'h00, u_hcm_host_model.rej});
    h(8'h01, 8'h00, 16'h0be0, "", 81, 0);
    chk("moved reply src", 8'h09, u_hcm_host_model.rx[0]);
    $display("test map done");
  endtask

  task automatic t_queue();
    string s;
    int k;
    s = "";
    repeat (299) s = {s, "a"};
    @(posedge clk);
    cmd_ready <= 1'b0;
    cmds = "";
    h(8'h08, 8'h0a, 16'h0bb8, s, 0, 0);
    chk("not full at 299", 8'h00, {7'h00, cmd_full});
    h(8'h08, 8'h0a, 16'h0bb8, "\015", 0, 0);
    chk("full at 300", 8'h01, {7'h00, cmd_full});
    cmd_ready <= 1'b1;
    for (k = 0; k < 400 && cmds.len() < 300; k++) @(posedge clk);
    chk("drained", 8'd44, 8'(cmds.len()));
    $display("test queue done");
  endtask

  initial begin
    rst = 1'b1;
    map_we = 1'b0;
    map = '0;
    cmd_ready = 1'b1;
    cmd_pending = 1'b0;
    rep_valid = 1'b0;
    rep_char = 8'h00;
    cmds = "";
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_write();
    t_blocks();
    t_clear();
    t_abort();
    t_map();
    t_queue();
    give_verdict();
  end
endmodule
`default_nettype wire
